// ### design/scb_defs.vh
// Register offsets, field positions, reset values and divider codes of the serial channel 2 configuration block.
// Assumes a 32-bit AXI4-Lite register bus where each register takes one aligned word.
`ifndef SCB_DEFS_VH
`define SCB_DEFS_VH

// Register byte offsets within the block's window, taken from the low address bits.
`define SCB_OFF_BAUD       8'h00
`define SCB_OFF_ASYNC      8'h04
`define SCB_OFF_CHMODE     8'h08
`define SCB_OFF_OSC        8'h0c
`define SCB_OFF_STATUS     8'h10
`define SCB_BAUD_ADDR_DOC  16'hff73

// Reset values.
`define SCB_RST_BYTE       8'h00

// Asynchronous mode register fields.
`define SCB_AS_CLKSEL      0
`define SCB_AS_ERRMASK     1
`define SCB_AS_STOP        2
`define SCB_AS_CHARLEN     3
`define SCB_AS_PAR_LO      4
`define SCB_AS_PAR_HI      5
`define SCB_AS_RXEN        6
`define SCB_AS_TXEN        7

// Channel mode control: bits that must stay zero.
`define SCB_CH_MUSTZERO    8'h79

// Prescale source codes and divider constants.
`define SCB_PS_MAX         4'h0
`define SCB_PS_FIRST       4'h5
`define SCB_PS_LAST        4'he
`define SCB_K_BYPASS       4'hf
`define SCB_K_BASE         5'h10

// AXI responses.
`define SCB_RESP_OKAY      2'b00
`define SCB_RESP_SLVERR    2'b10

`endif

// ### design/scb_serial_cfg.v
// Configuration registers and baud generator of serial channel 2 with an AXI4-Lite slave.
// Assumes one 20 MHz clock, a synchronous active-low reset and a single-beat AXI4-Lite master.
`default_nettype none
`include "scb_defs.vh"

// Notes on behaviour
// R1 - The clocked three-wire mode is set up through channel mode, asynchronous mode and baud control together.
// R2 - Reset clears channel mode control to zero and software may write it per bit or per byte.
// R3 - Software keeps bit 0 and bits 3 to 6 of channel mode control at zero.
// R4 - The asynchronous mode register takes bit or byte writes and resets to zero.
// R5 - Software holds the asynchronous mode register at zero while the three-wire mode is in use.
// R6 - Asynchronous mode bit 0 picks the external clock pin at zero or the baud generator at one.
// R7 - Asynchronous mode bit 1 at one suppresses the completion interrupt on a receive error.
// R8 - Asynchronous mode bits 2, 3 and 5:4 give stop length, character length and parity.
// R9 - Bit 7 enables transmit, bit 6 enables receive, and clearing receive stops it at once.
// R10 - Baud control takes only whole-byte writes and resets to zero.
// R11 - Baud bits 3:0 divide the counter source by 16+k for k 0 to 14, and 1111 passes it through.
// R12 - Baud bits 7:4 pick the source as the main clock over 2^10 for 0000 or 2^(n-1) for codes 0101 to 1110.
// R13 - The main clock is the oscillator clock when the halving select is one, else half of it.
// R14 - Software does not write baud control while a transfer runs.
// R15 - With the divider bypassed the serial clock equals the counter source clock.
// R16 - An external serial clock needs no baud control setting.
// R17 - A prohibited source code holds the generated serial clock stopped.
module scb_serial_cfg (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        osc_tick,
   input  wire        external_uart_clock_pin,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [7:0]  channel_mode_control,
   output reg  [7:0]  async_frame_mode,
   output reg         source_tick,
   output reg         serial_tick,
   output reg         uart_clock_tick,
   output reg         source_code_bad
);

   // Register storage.
   reg  [7:0]  baud_divider_control_reg;
   reg  [7:0]  async_frame_mode_reg;
   reg  [7:0]  channel_mode_control_reg;
   reg         main_clock_halving_select_reg;
   // Write channel capture.
   reg         aw_held_reg;
   reg         w_held_reg;
   reg  [7:0]  aw_addr_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   // Generator state.
   // The prescaler counts main ticks and the divider counts prescaler pulses.
   reg         half_reg;
   reg  [9:0]  pre_cnt_reg;
   reg  [4:0]  div_cnt_reg;
   reg         ext_pin_last_reg;

   wire        main_tick;
   wire        pre_done;
   wire        src_ok;
   wire [9:0]  pre_limit;
   wire        do_write;
   wire        ext_edge;

   // Prescale limit for a source code: cycles of main tick minus one, zero for pass-through.
   // Codes 0101 to 1110 count 2^(code-5) main ticks and code 0000 counts 1024.
   // Prohibited codes also return zero, but src_ok keeps the prescaler from counting then.
   function [9:0] scb_pre_limit;
      input [3:0] code;
      begin
         if (code == `SCB_PS_MAX) begin
            scb_pre_limit = 10'h3ff;
         end else if (code >= `SCB_PS_FIRST && code <= `SCB_PS_LAST) begin
            scb_pre_limit = (10'h001 << (code - `SCB_PS_FIRST)) - 10'h001;
         end else begin
            scb_pre_limit = 10'h000;
         end
      end
   endfunction

   // Legal source code check.
   function scb_src_legal;
      input [3:0] code;
      begin
         scb_src_legal = (code == `SCB_PS_MAX) || (code >= `SCB_PS_FIRST && code <= `SCB_PS_LAST);
      end
   endfunction

   // Main clock is the oscillator tick, or every second one when halving is chosen.
   // All generator pulses are one-cycle enables on aclk; no derived clock is made.
   assign main_tick = osc_tick & (main_clock_halving_select_reg | half_reg); // R13
   assign pre_limit = scb_pre_limit(baud_divider_control_reg[7:4]);             // R12
   assign src_ok    = scb_src_legal(baud_divider_control_reg[7:4]);             // R17
   assign pre_done  = main_tick & src_ok & (pre_cnt_reg == pre_limit);
   assign do_write  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign ext_edge  = external_uart_clock_pin & ~ext_pin_last_reg;

   // Oscillator halving toggle.
   // The phase runs whatever the halving select is, so a change of select acts at the next tick.
   always @(posedge aclk) begin
      if (!aresetn) begin
         half_reg <= 1'b0;
      end else if (osc_tick) begin
         half_reg <= ~half_reg;
      end
   end

   // Power-of-two prescaler producing the 5-bit counter source tick.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt_reg <= 10'h000;
         source_tick <= 1'b0;
      end else begin
         source_tick <= pre_done;                                              // R12
         if (!src_ok) begin
            pre_cnt_reg <= 10'h000;                                            // R17
         end else if (main_tick) begin
            pre_cnt_reg <= pre_done ? 10'h000 : pre_cnt_reg + 10'h001;
         end
      end
   end

   // Divide-by-(16+k) counter, bypassed for k of all ones.
   // The limit is an equality compare: shrinking k mid-count lets the counter pass its wrap first,
   // which is one reason baud control must not be written while a transfer runs.
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_reg <= 5'h00;
         serial_tick <= 1'b0;
      end else if (baud_divider_control_reg[3:0] == `SCB_K_BYPASS) begin
         div_cnt_reg <= 5'h00;
         serial_tick <= pre_done;                                              // R15
      end else if (pre_done) begin
         if (div_cnt_reg == `SCB_K_BASE + {1'b0, baud_divider_control_reg[3:0]} - 5'h01) begin
            div_cnt_reg <= 5'h00;
            serial_tick <= 1'b1;                                               // R11
         end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
            serial_tick <= 1'b0;
         end
      end else begin
         serial_tick <= 1'b0;
      end
   end

   // UART clock select between the external pin edge and the generator.
   // In bypass the prescaler pulse is taken directly, so the tick lines up with serial_tick.
   // The pin detector resets low, so a pin already high at reset release gives one tick.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ext_pin_last_reg <= 1'b0;
         uart_clock_tick  <= 1'b0;
         source_code_bad  <= 1'b0;
      end else begin
         ext_pin_last_reg <= external_uart_clock_pin;
         uart_clock_tick  <= async_frame_mode_reg[`SCB_AS_CLKSEL] ?
                             (baud_divider_control_reg[3:0] == `SCB_K_BYPASS ? pre_done : serial_tick) :
                             ext_edge;                                         // R6
         source_code_bad  <= ~src_ok;
      end
   end

   // Write address and data are taken independently and held until the response.
   // Each ready is a one-cycle pulse so a valid that is still held is not taken twice.
   // A captured pair waits while an earlier write response is still unanswered.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr[7:0];
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Register writes and the write response.
   // Only strobe lane 0 carries a register; a bit write is done as a read-modify-write of the byte.
   always @(posedge aclk) begin
      if (!aresetn) begin
         baud_divider_control_reg      <= `SCB_RST_BYTE;                       // R10
         async_frame_mode_reg          <= `SCB_RST_BYTE;                       // R4
         channel_mode_control_reg      <= `SCB_RST_BYTE;                       // R2
         main_clock_halving_select_reg <= 1'b0;
         s_axi_bvalid                  <= 1'b0;
         s_axi_bresp                   <= `SCB_RESP_OKAY;
      end else begin
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `SCB_RESP_OKAY;
            case (aw_addr_reg)
               `SCB_OFF_BAUD: begin
                  if (w_strb_reg[0]) begin
                     baud_divider_control_reg <= w_data_reg[7:0];               // R10
                  end
               end
               `SCB_OFF_ASYNC: begin
                  if (w_strb_reg[0]) begin
                     async_frame_mode_reg <= w_data_reg[7:0];                   // R4 R8 R9
                  end
               end
               `SCB_OFF_CHMODE: begin
                  if (w_strb_reg[0]) begin
                     channel_mode_control_reg <= w_data_reg[7:0];               // R2 R1
                  end
               end
               `SCB_OFF_OSC: begin
                  if (w_strb_reg[0]) begin
                     main_clock_halving_select_reg <= w_data_reg[0];            // R13
                  end
               end
               `SCB_OFF_STATUS: begin
                  s_axi_bresp <= `SCB_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `SCB_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // Read channel: one read at a time, answered the cycle after the address is taken.
   // Unmapped offsets read zero with a slave error; the status word is built at each read.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SCB_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SCB_RESP_OKAY;
            case (s_axi_araddr[7:0])
               `SCB_OFF_BAUD:   s_axi_rdata <= {24'h000000, baud_divider_control_reg};
               `SCB_OFF_ASYNC:  s_axi_rdata <= {24'h000000, async_frame_mode_reg};
               `SCB_OFF_CHMODE: s_axi_rdata <= {24'h000000, channel_mode_control_reg};
               `SCB_OFF_OSC:    s_axi_rdata <= {31'h00000000, main_clock_halving_select_reg};
               `SCB_OFF_STATUS: s_axi_rdata <= {27'h0000000, div_cnt_reg == 5'h00, ~src_ok,
                                                 |(channel_mode_control_reg & `SCB_CH_MUSTZERO),
                                                 async_frame_mode_reg != 8'h00, half_reg};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `SCB_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // Register copies to the UART and three-wire logic; error mask and enables act downstream.
   // The copies lag the registers by one cycle, so downstream logic sees a write one cycle late.
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_mode_control <= `SCB_RST_BYTE;
         async_frame_mode     <= `SCB_RST_BYTE;
      end else begin
         channel_mode_control <= channel_mode_control_reg;                     // R3 R16
         async_frame_mode     <= async_frame_mode_reg;                         // R5 R7 R9 R14
      end
   end

endmodule
`default_nettype wire

// ### testbench/scb_cfg_asserts.sv
// Port checker for the serial channel 2 configuration block.
// Assumes one clock aclk and a synchronous active-low reset aresetn.
`default_nettype none
module scb_cfg_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        external_uart_clock_pin,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [7:0]  channel_mode_control,
   input wire logic [7:0]  async_frame_mode,
   input wire logic        source_tick,
   input wire logic        serial_tick,
   input wire logic        uart_clock_tick,
   input wire logic        source_code_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks share the one clock and its reset.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   write_answer_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready, 2))
      else $error("write answer not two cycles after address taken");
   read_answer_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
      else $error("read answer not one cycle after address taken");
   ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("address ready held longer than one cycle");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer kept after being taken");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   reset_clear_a: assert property ($rose(aresetn) |-> {async_frame_mode, channel_mode_control} == 16'h0)
      else $error("mode registers not clear after reset");
   code_stop_a: assert property (source_code_bad && $past(source_code_bad, 2) |-> !serial_tick && !source_tick)
      else $error("generator runs on a prohibited source code");
   pin_clock_a: assert property ($rose(external_uart_clock_pin) && !async_frame_mode[0] |=> uart_clock_tick)
      else $error("pin edge gave no clock tick");
   // Main scenarios reached.
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (serial_tick);
   cover property (source_code_bad);
endmodule
bind scb_serial_cfg scb_cfg_asserts u_scb_cfg_asserts (
   .aclk(aclk), .aresetn(aresetn), .external_uart_clock_pin(external_uart_clock_pin),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .channel_mode_control(channel_mode_control), .async_frame_mode(async_frame_mode),
   .source_tick(source_tick), .serial_tick(serial_tick), .uart_clock_tick(uart_clock_tick),
   .source_code_bad(source_code_bad));
`default_nettype wire

// ### testbench/serial_ch2_mode_baud_config_test.sv
// Self-checking bench for the serial channel 2 configuration block.
// Assumes the design, its header and the checker are compiled first.
`default_nettype none
module serial_ch2_mode_baud_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, osc_tick, pin, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, src_t, ser_t, uart_t, bad;
   logic [31:0] awaddr, wdata, araddr, rdata, seed, d, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [7:0]  chm, afm, b;
   logic [7:0]  at [0:5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h40};
   int          n_fail, tests_run, p, cnt, mdl [0:3];
   int          cyc = 0;
   wire  [2:0]  tk = {uart_t, src_t, ser_t};
   scb_serial_cfg u_scb_serial_cfg (
      .aclk(aclk), .aresetn(aresetn), .osc_tick(osc_tick), .external_uart_clock_pin(pin),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .channel_mode_control(chm), .async_frame_mode(afm), .source_tick(src_t),
      .serial_tick(ser_t), .uart_clock_tick(uart_t), .source_code_bad(bad));
   // Clock of 50 ns period.
   initial begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end
   // A hang counts as a mismatch.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         wrap_up();
      end
   end
   // Pseudo-random source with a fixed start.
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected tick period in clocks with one oscillator tick per clock.
   function automatic int ep(input int o, input logic [7:0] c);
      int n;
      n = (c[7:4] == 4'h0) ? 11 : c[7:4] - 4;
      return (1 << (n - 1)) * ((c[3:0] == 4'hf) ? 1 : 16 + c[3:0]) * (o ? 1 : 2);
   endfunction
   // Compares one value and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One write; the model follows a taken low byte.
   task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [3:0] s);
      logic ga, gw;
      ga = 0;
      gw = 0;
      awaddr <= {24'h0, a};
      wdata <= x;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ga && gw)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ga = 1;
            awvalid <= 0;
         end
         if (wvalid && wready) begin
            gw = 1;
            wvalid <= 0;
         end
      end
      while (!bvalid) @(posedge aclk);
      bready <= 0;
      chk(bresp, (a[1:0] == 0 && a <= 8'h10) ? 0 : 2, "write response");
      if (s[0] && a < 8'h10 && a[1:0] == 0) mdl[a[3:2]] = (a == 8'h0c) ? x[0] : x[7:0];
      @(posedge aclk);
   endtask
   // One read, compared with the model except for the status word.
   task automatic rd(input logic [7:0] a, output logic [31:0] x);
      araddr <= {24'h0, a};
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge aclk);
      x = rdata;
      rready <= 0;
      chk(rresp, (a[1:0] == 0 && a <= 8'h10) ? 0 : 2, "read response");
      if (a != 8'h10) chk(x, (a < 8'h10 && a[1:0] == 0) ? mdl[a[3:2]] : 0, "read data");
      @(posedge aclk);
   endtask
   // Clocks between ticks, skipping the intervals a write disturbed.
   task automatic per(input int s, output int q);
      repeat (2) do @(posedge aclk); while (!tk[s]);
      q = 0;
      do begin
         @(posedge aclk);
         q++;
      end while (!tk[s]);
   endtask
   // Main sequence.
   initial begin
      seed = 32'h2e6553d9;
      {aresetn, osc_tick, pin, awvalid, wvalid, bready, arvalid, rready} = 0;
      {awaddr, wdata, araddr, wstrb} = 0;
      n_fail = 0;
      tests_run = 0;
      mdl = '{0, 0, 0, 0};
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      osc_tick <= 1;
      @(posedge aclk);
      for (int i = 0; i < 5; i++) rd(8'(i * 4), d);
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         d = xs();
         b = at[d[31:29] % 6];
         v = (b == 8'h08) ? xs() & ~32'h79 : xs();
         wr(b, v, d[3:0]);
         rd(b, v);
         chk(afm, mdl[1], "async mode out");
         chk(chm, mdl[2], "channel mode out");
      end
      $display("test random done");
      wr(8'h0c, 1, 4'h1);
      for (int t = 4; t < 15; t++) begin
         b = (t == 4) ? 8'h0f : {t[3:0], 4'hf};
         wr(0, b, 4'h1);
         per(1, p);
         chk(p, ep(1, b), "source period");
         per(0, p);
         chk(p, ep(1, b), "bypass period");
      end
      for (int k = 0; k < 15; k += 7) begin
         b = {4'h6, k[3:0]};
         wr(0, b, 4'h1);
         per(0, p);
         chk(p, ep(1, b), "divided period");
      end
      wr(8'h0c, 0, 4'h1);
      wr(0, 8'h50, 4'h1);
      per(0, p);
      chk(p, ep(0, 8'h50), "halved period");
      $display("test divider done");
      for (int c = 1; c < 16; c = (c == 4) ? 15 : c + 1) begin
         wr(0, {c[3:0], 4'hf}, 4'h1);
         repeat (3) @(posedge aclk);
         cnt = 0;
         repeat (40) begin
            @(posedge aclk);
            cnt += ser_t | src_t;
         end
         chk(cnt, 0, "stopped ticks");
         chk(bad, 1, "bad code flag");
         rd(8'h10, v);
         chk(v[3], 1, "status bad code");
      end
      $display("test prohibited done");
      wr(8'h04, 0, 4'h1);
      cnt = 0;
      for (int j = 0; j < 46; j++) begin
         @(posedge aclk);
         pin <= (j % 10 < 5) && j < 40;
         cnt += uart_t;
      end
      chk(cnt, 4, "pin clock ticks");
      wr(8'h04, 1, 4'h1);
      wr(8'h0c, 1, 4'h1);
      wr(0, 8'h50, 4'h1);
      per(2, p);
      chk(p, 16, "generator clock");
      $display("test clocks done");
      wrap_up();
   end
endmodule
`default_nettype wire
